// *** rtl/ebi_map.svh ***
// Constants of the external bus port: timing counts, the beat address step and reset levels.
// Assumes inclusion by bare name from the port module.
`ifndef EBI_MAP_SVH
`define EBI_MAP_SVH
`define EBI_ACK_TIMEOUT_COUNT 1022
`define EBI_BCLK_HALF_PERIOD 4
`define EBI_FIRST_ACCESS_WAIT 4'h6
`define EBI_BEAT_ADDR_STEP 25'h0000004
`define EBI_PFS_RESET 2'h0
`define EBI_CS_IDLE 6'h3f
`define EBI_STROBE_IDLE 4'hf
`endif

// *** rtl/ebi_pkg.sv ***
// Types shared by the external bus port modules.
// Assumes the map header supplies every numeric constant.
package ebi_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_ACCESS, ST_LATCH, ST_BEAT, ST_END} bus_state_t;

   typedef struct packed {
      logic write;
      logic [24:0] addr;
      logic [31:0] wdata;
      logic [3:0] byte_en;
      logic [2:0] cs;
      logic burst;
      logic [3:0] beats;
   } req_t;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
      logic bus_error;
   } rsp_t;

   typedef struct packed {
      logic [24:0] addr;
      logic [31:0] dout;
      logic doe;
      logic [3:0] byte_strobe_n;
      logic oe_n;
      logic rw;
      logic [5:0] cs_n;
      logic burst_clk;
      logic burst_address_latch_n;
   } pins_t;

   typedef struct packed {
      bus_state_t st;
      req_t req;
      pins_t pins;
      rsp_t rsp;
      logic ready;
      logic ack_mode;
      logic [9:0] wait_cnt;
      logic [2:0] div_cnt;
      logic [3:0] first_cnt;
      logic [3:0] beats_left;
      logic restart_prev;
      logic [1:0] pin_function_select_register;
      logic [5:0] cs_pin_n;
   } port_state_t;
endpackage : ebi_pkg

// *** rtl/pin_sync.sv ***
// Three-stage synchroniser for active-low pins from outside the clock domain.
// Assumes the pins idle high; a change counts once the second and third stages agree.
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 2
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_state_t;

   sync_state_t r;
   sync_state_t n;

   initial begin
      if (W < 1) $error("pin_sync needs at least one bit");
   end

   always_comb begin
      n.s1 = pin_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.lvl = r.lvl;
      for (int i = 0; i < W; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            n.lvl[i] = r.s3[i];
         end
      end
      if (!rst_n) begin
         n = '1;
      end
   end

   always_ff @(posedge ref_clk) begin
      r <= n;
   end

   assign level = r.lvl;
endmodule : pin_sync

// *** rtl/external_bus_chip_select_port.sv ***
// External memory bus port: single accesses, burst reads, chip selects and pin sharing.
// Assumes one request at a time from the internal side and asynchronous acknowledge and restart pins.
`timescale 1ns/10ps
`include "ebi_map.svh"
module external_bus_chip_select_port #(
   parameter int ACK_TIMEOUT = `EBI_ACK_TIMEOUT_COUNT,
   parameter int BCLK_HALF = `EBI_BCLK_HALF_PERIOD
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire ebi_pkg::req_t req,
   output logic req_ready,
   output ebi_pkg::rsp_t rsp,
   input wire logic [5:0] cs_use_ack,
   input wire logic [23:0] cs_wait_states,
   input wire logic [1:0] pin_function_select_in,
   input wire logic [1:0] sdram_chip_select_n,
   output logic [24:0] addr,
   output logic [31:0] data_out,
   output logic data_oe,
   input wire logic [31:0] data_in,
   output logic [3:0] byte_strobe_n,
   output logic oe_n,
   output logic rw,
   output logic [5:0] cs_n,
   output logic burst_clk,
   output logic burst_address_latch_n,
   input wire logic burst_restart_request_n,
   input wire logic external_data_acknowledge_n
);
   ebi_pkg::port_state_t r;
   ebi_pkg::port_state_t n;
   logic [1:0] sync_lvl;
   logic ack_lvl_n;
   logic restart_lvl_n;
   logic bclk_rise;

   initial begin
      if (ACK_TIMEOUT < 2 || ACK_TIMEOUT > 1023) $error("ACK_TIMEOUT must be 2 to 1023");
      if (BCLK_HALF < 1 || BCLK_HALF > 8) $error("BCLK_HALF must be 1 to 8");
   end

   // Strobe 0 carries the most significant lane, so the enable order is reversed.
   function automatic logic [3:0] lane_strobes_n(input logic [3:0] byte_en);
      return ~{byte_en[0], byte_en[1], byte_en[2], byte_en[3]};
   endfunction : lane_strobes_n

   function automatic logic [5:0] cs_onehot_n(input logic [2:0] cs);
      logic [5:0] v;
      v = `EBI_CS_IDLE;
      if (cs < 3'h6) v[cs] = 1'b0;
      return v;
   endfunction : cs_onehot_n

   // Selects 6 and 7 drive no pin, so they end at once instead of reading past the table.
   function automatic logic [3:0] wait_limit(input logic [2:0] cs, input logic [23:0] waits);
      return (cs < 3'h6) ? waits[4*cs +: 4] : 4'h0;
   endfunction : wait_limit

   pin_sync #(.W(2)) u_sync (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pin_in({burst_restart_request_n, external_data_acknowledge_n}),
      .level(sync_lvl)
   );
   assign ack_lvl_n = sync_lvl[0];
   assign restart_lvl_n = sync_lvl[1];

   always_comb begin
      n = r;
      bclk_rise = 1'b0;
      n.rsp.valid = 1'b0;
      n.rsp.bus_error = 1'b0;
      n.restart_prev = restart_lvl_n;
      n.pin_function_select_register = pin_function_select_in;
      if (r.st == ebi_pkg::ST_LATCH || r.st == ebi_pkg::ST_BEAT) begin
         if (r.div_cnt == 3'(BCLK_HALF - 1)) begin
            n.div_cnt = 3'h0;
            n.pins.burst_clk = ~r.pins.burst_clk;
            bclk_rise = ~r.pins.burst_clk;
         end else begin
            n.div_cnt = r.div_cnt + 3'h1;
         end
      end else begin
         n.div_cnt = 3'h0;
         n.pins.burst_clk = 1'b0;
      end
      case (r.st)
         ebi_pkg::ST_IDLE: begin
            n.ready = 1'b1;
            if (req_valid && r.ready) begin
               n.req = req;
               n.ready = 1'b0;
               n.wait_cnt = 10'h000;
               n.ack_mode = (req.cs < 3'h6) ? cs_use_ack[req.cs] : 1'b0;
               n.pins.addr = req.addr;
               n.pins.cs_n = cs_onehot_n(req.cs);
               n.pins.byte_strobe_n = lane_strobes_n(req.byte_en);
               if (req.burst) begin
                  // Bursts are reads only, so write data is never driven here.
                  n.st = ebi_pkg::ST_LATCH;
                  n.pins.rw = 1'b1;
                  n.pins.oe_n = 1'b0;
                  n.pins.burst_address_latch_n = 1'b0;
                  n.first_cnt = `EBI_FIRST_ACCESS_WAIT;
                  n.beats_left = (req.beats == 4'h0) ? 4'h1 : req.beats;
               end else begin
                  n.st = ebi_pkg::ST_ACCESS;
                  n.pins.rw = ~req.write;
                  n.pins.oe_n = req.write;
                  n.pins.doe = req.write;
                  n.pins.dout = req.wdata;
               end
            end
         end
         ebi_pkg::ST_ACCESS: begin
            if (r.ack_mode) begin
               if (!ack_lvl_n) begin
                  n.st = ebi_pkg::ST_END;
               end else if (r.wait_cnt == 10'(ACK_TIMEOUT - 1)) begin
                  n.st = ebi_pkg::ST_END;
                  n.rsp.bus_error = 1'b1;
               end else begin
                  n.wait_cnt = r.wait_cnt + 10'h001;
               end
            end else if (r.wait_cnt[3:0] == wait_limit(r.req.cs, cs_wait_states)) begin
               n.st = ebi_pkg::ST_END;
            end else begin
               n.wait_cnt = r.wait_cnt + 10'h001;
            end
            if (n.st == ebi_pkg::ST_END) begin
               n.rsp.valid = 1'b1;
               n.rsp.rdata = r.req.write ? 32'h00000000 : data_in;
            end
         end
         ebi_pkg::ST_LATCH: begin
            if (bclk_rise) begin
               n.pins.burst_address_latch_n = 1'b1;
               if (r.first_cnt <= 4'h1) begin
                  n.st = ebi_pkg::ST_BEAT;
               end else begin
                  n.first_cnt = r.first_cnt - 4'h1;
               end
            end
         end
         ebi_pkg::ST_BEAT: begin
            if (!restart_lvl_n && r.restart_prev) begin
               // Restart from the next unread address with the long first access.
               n.st = ebi_pkg::ST_LATCH;
               n.pins.burst_address_latch_n = 1'b0;
               n.first_cnt = `EBI_FIRST_ACCESS_WAIT;
            end else if (bclk_rise) begin
               n.rsp.valid = 1'b1;
               n.rsp.rdata = data_in;
               n.pins.addr = r.pins.addr + `EBI_BEAT_ADDR_STEP;
               n.beats_left = r.beats_left - 4'h1;
               if (r.beats_left == 4'h1) begin
                  n.st = ebi_pkg::ST_END;
               end
            end
         end
         ebi_pkg::ST_END: begin
            // A synchronised acknowledge still low belongs to this cycle and would end the next one early.
            if (!r.ack_mode || ack_lvl_n) begin
               n.st = ebi_pkg::ST_IDLE;
            end
         end
         default: begin
            n.st = ebi_pkg::ST_IDLE;
         end
      endcase
      if (n.st == ebi_pkg::ST_END) begin
         n.pins.cs_n = `EBI_CS_IDLE;
         n.pins.byte_strobe_n = `EBI_STROBE_IDLE;
         n.pins.oe_n = 1'b1;
         n.pins.doe = 1'b0;
         n.pins.rw = 1'b1;
         n.pins.burst_address_latch_n = 1'b1;
         n.pins.burst_clk = 1'b0;
      end
      n.cs_pin_n = n.pins.cs_n;
      // Shared pins follow the select bits; zero hands the pin to the SDRAM controller.
      if (!r.pin_function_select_register[0]) n.cs_pin_n[2] = sdram_chip_select_n[0];
      if (!r.pin_function_select_register[1]) n.cs_pin_n[3] = sdram_chip_select_n[1];
      if (!rst_n) begin
         n = '0;
         n.st = ebi_pkg::ST_IDLE;
         n.pins.cs_n = `EBI_CS_IDLE;
         n.cs_pin_n = `EBI_CS_IDLE;
         n.pins.byte_strobe_n = `EBI_STROBE_IDLE;
         n.pins.oe_n = 1'b1;
         n.pins.rw = 1'b1;
         n.pins.burst_address_latch_n = 1'b1;
         n.restart_prev = 1'b1;
         n.pin_function_select_register = `EBI_PFS_RESET;
      end
   end

   always_ff @(posedge ref_clk) begin
      r <= n;
   end

   assign req_ready = r.ready;
   assign rsp = r.rsp;
   assign addr = r.pins.addr;
   assign data_out = r.pins.dout;
   assign data_oe = r.pins.doe;
   assign byte_strobe_n = r.pins.byte_strobe_n;
   assign oe_n = r.pins.oe_n;
   assign rw = r.pins.rw;
   assign cs_n = r.cs_pin_n;
   assign burst_clk = r.pins.burst_clk;
   assign burst_address_latch_n = r.pins.burst_address_latch_n;
endmodule : external_bus_chip_select_port

// *** bench/ebi_checker.sv ***
// Pin and response assertions for the external bus port.
// Assumes requests name chip selects 0 to 5.
`timescale 1ns/10ps
module ebi_checker #(
   parameter int ACK_TIMEOUT = 1022
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire ebi_pkg::req_t req,
   input wire ebi_pkg::rsp_t rsp,
   input wire logic [5:0] cs_use_ack,
   input wire logic [1:0] pin_function_select_in,
   input wire logic [1:0] sdram_chip_select_n,
   input wire logic [5:0] cs_n,
   input wire logic [3:0] byte_strobe_n,
   input wire logic oe_n,
   input wire logic rw,
   input wire logic burst_clk,
   input wire logic burst_address_latch_n
);
   logic [10:0] cnt_reg;
   logic ack_reg;
   logic take;
   logic [3:0] lanes_n;
   assign take = req_valid && req_ready;
   assign lanes_n = ~{req.byte_en[0], req.byte_en[1], req.byte_en[2], req.byte_en[3]};
   // The counter saturates so a stuck cycle cannot wrap into a false match.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_reg <= 11'h000;
         ack_reg <= 1'b0;
      end else if (take) begin
         cnt_reg <= 11'h000;
         ack_reg <= (req.cs < 3'h6) && cs_use_ack[req.cs];
      end else if (cnt_reg != 11'h7ff) begin
         cnt_reg <= cnt_reg + 11'h001;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   property p_lanes; take && !req.burst |=> byte_strobe_n == $past(lanes_n); endproperty
   a_lanes: assert property (p_lanes) else $error("strobes differ from lanes");
   property p_oe; !oe_n |-> rw; endproperty
   a_oe: assert property (p_oe) else $error("output enable on write");
   property p_share; $past(rst_n) && $past(rst_n, 2) && $past(pin_function_select_in, 2) == 2'h0
      |-> cs_n[3:2] == $past(sdram_chip_select_n); endproperty
   a_share: assert property (p_share) else $error("shared selects wrong");
   property p_latch; !burst_address_latch_n |-> !oe_n && rw; endproperty
   a_latch: assert property (p_latch) else $error("latch outside burst");
   property p_bclk; $rose(burst_clk) |-> !oe_n && rw; endproperty
   a_bclk: assert property (p_bclk) else $error("burst clock outside burst");
   property p_rw; take |=> rw == !$past(req.write); endproperty
   a_rw: assert property (p_rw) else $error("read write level wrong");
   property p_timeout; rsp.valid && rsp.bus_error
      |-> ack_reg && cnt_reg >= ACK_TIMEOUT && cnt_reg <= ACK_TIMEOUT + 3; endproperty
   a_timeout: assert property (p_timeout) else $error("bus error at wrong time");
   property p_noack; rsp.valid && !ack_reg |-> !rsp.bus_error; endproperty
   a_noack: assert property (p_noack) else $error("bus error without acknowledge");
   c_err: cover property (rsp.valid && rsp.bus_error);
   c_latch: cover property ($fell(burst_address_latch_n));
   c_write: cover property (take ##1 !rw);
endmodule : ebi_checker
bind external_bus_chip_select_port ebi_checker #(.ACK_TIMEOUT(ACK_TIMEOUT)) chk_i (.*);

// *** bench/flash_model.sv ***
// Memory model on the far side of the port pins.
// Assumes the bench sets acknowledge delay and restart request.
`timescale 1ns/10ps
module flash_model (
   input wire logic ref_clk,
   input wire logic [24:0] addr,
   input wire logic [5:0] cs_n,
   input wire logic oe_n,
   input wire logic [3:0] ack_delay,
   input wire logic restart_go,
   output logic [31:0] data_in,
   output logic external_data_acknowledge_n,
   output logic burst_restart_request_n
);
   logic [3:0] cnt_reg;
   logic sel;
   assign sel = cs_n != 6'h3f;
   initial begin
      data_in = 32'h0;
      external_data_acknowledge_n = 1'b1;
      burst_restart_request_n = 1'b1;
      cnt_reg = 4'h0;
   end
   // A released bus shows inverted junk, so stale data never matches.
   always @(posedge ref_clk) begin
      cnt_reg <= sel ? cnt_reg + 4'h1 : 4'h0;
      external_data_acknowledge_n <= !(sel && ack_delay != 4'h0 && cnt_reg >= ack_delay);
      data_in <= (sel && !oe_n) ? {7'h5a, addr} : ~data_in;
      burst_restart_request_n <= !restart_go;
   end
endmodule : flash_model

// *** bench/test_external_bus_chip_select_port.sv ***
// Self-checking bench for the external bus port.
// Assumes a 40 MHz clock and a time-out shortened to 16 clocks.
`timescale 1ns/10ps
module test_external_bus_chip_select_port;
   logic ref_clk, rst_n, req_valid, req_ready, data_oe, oe_n, rw, burst_clk, burst_address_latch_n;
   logic burst_restart_request_n, external_data_acknowledge_n, restart_go, err, lp, saw_rw0, saw_oe0, saw_bclk;
   ebi_pkg::req_t req;
   ebi_pkg::rsp_t rsp;
   logic [5:0] cs_use_ack, cs_n, cs_acc;
   logic [23:0] cs_wait_states;
   logic [1:0] pin_function_select_in, sdram_chip_select_n;
   logic [24:0] addr;
   logic [31:0] data_out, data_in, rdata, wd;
   logic [3:0] byte_strobe_n, sb, ack_delay;
   int mismatches = 0;
   int checks = 0;
   int beats, lats;
   int cycles = 0;
   external_bus_chip_select_port #(.ACK_TIMEOUT(16), .BCLK_HALF(4)) dut (.*);
   flash_model mem (.*);
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [2:0] c, input logic b, input logic [3:0] n,
      input logic [3:0] be, input logic kick);
      int i;
      @(posedge ref_clk);
      #1 req_valid = 1'b1;
      req = '{w, 25'h0000100, 32'hc3a55a3c, be, c, b, n};
      for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(posedge ref_clk) #1;
      @(posedge ref_clk);
      #1 req_valid = 1'b0;
      {beats, lats, err, lp, saw_rw0, saw_oe0, saw_bclk, cs_acc, sb} = {64'h0, 5'h08, 10'h3ff};
      wd = 32'h0;
      for (i = 0; i < 3000 && beats < n; i++) begin
         @(posedge ref_clk) #1;
         restart_go = kick && beats == 1;
         if (burst_address_latch_n === 1'b0 && lp) lats++;
         lp = burst_address_latch_n;
         cs_acc = cs_acc & cs_n;
         if (byte_strobe_n !== 4'hf) sb = byte_strobe_n;
         if (data_oe === 1'b1) wd = data_out;
         saw_rw0 = saw_rw0 | (rw === 1'b0);
         saw_oe0 = saw_oe0 | (oe_n === 1'b0);
         saw_bclk = saw_bclk | (burst_clk === 1'b1);
         if (rsp.valid === 1'b1) begin
            beats++;
            rdata = rsp.rdata;
            err = rsp.bus_error;
         end
      end
      restart_go = 1'b0;
   endtask : xfer
   task t_single;
      xfer(1'b1, 3'h0, 1'b0, 4'h1, 4'h8, 1'b0);
      chk({sb, saw_rw0, err}, 6'h3a);
      chk(wd, 32'hc3a55a3c);
      xfer(1'b0, 3'h1, 1'b0, 4'h1, 4'h3, 1'b0);
      chk({sb, saw_oe0, saw_rw0, rdata[31:25]}, 13'h075a);
      chk(wd, 32'h00000000);
   endtask : t_single
   task t_cs;
      int k;
      pin_function_select_in = 2'h3;
      for (k = 0; k < 6; k++) begin
         xfer(1'b0, k[2:0], 1'b0, 4'h1, 4'hf, 1'b0);
         chk(cs_acc, 6'(~(6'h01 << k)));
      end
      pin_function_select_in = 2'h0;
      sdram_chip_select_n = 2'h2;
      repeat (3) @(posedge ref_clk);
      #1 chk(cs_n[3:2], 2'h2);
      sdram_chip_select_n = 2'h3;
   endtask : t_cs
   task t_ack;
      xfer(1'b1, 3'h4, 1'b0, 4'h1, 4'hf, 1'b0);
      chk(err, 1'b0);
      ack_delay = 4'h0;
      xfer(1'b0, 3'h4, 1'b0, 4'h1, 4'hf, 1'b0);
      chk({beats[1:0], err}, 3'h3);
   endtask : t_ack
   task t_burst;
      xfer(1'b0, 3'h0, 1'b1, 4'h3, 4'hf, 1'b0);
      chk({beats[3:0], lats[1:0], saw_bclk, rdata[31:25]}, 14'h0dda);
      chk(addr, 25'h000010c);
      xfer(1'b0, 3'h0, 1'b1, 4'h4, 4'hf, 1'b1);
      chk({beats[3:0], lats[1:0]}, 6'h12);
   endtask : t_burst
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up;
      end
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      restart_go = 1'b0;
      cs_use_ack = 6'h10;
      cs_wait_states = 24'h222222;
      pin_function_select_in = 2'h0;
      sdram_chip_select_n = 2'h3;
      ack_delay = 4'h3;
      repeat (16) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      t_single;
      t_cs;
      t_ack;
      t_burst;
      wrap_up;
   end
endmodule : test_external_bus_chip_select_port
